// *** rtc_div_if.sv ***
// Purpose: carrier between register side and oscillator-side divider
// Assumes: all ctrl outputs are flops or quasi-static levels
// Notes: every signal crosses clock domains; receivers synchronise
`timescale 1ns/1ps
`default_nettype none
interface rtc_div_if;
  logic [7:0] trimCode;
  logic trimSecond;
  logic resetLevel;
  logic tickToggle;

  modport ctrl (output trimCode, output trimSecond, output resetLevel, input tickToggle);
  modport div (input trimCode, input trimSecond, input resetLevel, output tickToggle);
endinterface : rtc_div_if
`default_nettype wire

// *** rtc_host_model.sv ***
// Purpose: host side of the register port of the rtc trim/alarm block
// Assumes: one-cycle write strobe, registered read data
// Notes: drives off the falling edge only
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  input wire logic clock,
  output logic regWrite,
  output logic [3:0] regAddr,
  output logic [7:0] regWdata
);
  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
  end

  // one write: strobe held across exactly one rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    regWdata = ~d; // released data must not look stale
  endtask : wr

  // present an address and wait until its data has settled
  task automatic pointTo(input logic [3:0] a);
    @(negedge clock);
    regAddr = a;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : pointTo
endmodule : rtc_host_model
`default_nettype wire

// *** rtc_pkg.sv ***
// Purpose: shared types of the rtc trim/alarm block
// Assumes: nothing beyond the register header
// Notes: no constants here, only types
package rtc_pkg;
  // one alarm register set
  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [6:0] weekdays;
  } rtc_alarm_s;

  typedef logic [7:0] rtc_byte_t;
endpackage : rtc_pkg

// *** rtc_regs.svh ***
// Purpose: register offsets, field layouts, reset values and counts of the rtc trim/alarm block
// Assumes: four-bit internal address, eight-bit register data
// Notes: definitions only
// Operation
// - year register at address 6, eight bits fully read-write, undefined after stop.
// - trim register at address 7: crystal select bit 7, adjustment bits 6..0, zero default.
// - crystal select zero times for 32.768 kHz, one for 32.000 kHz.
// - untrimmed second lasts 32768 pulses, or 32000 with the slower crystal.
// - trim applies only to the second counted while seconds read 00, 20 or 40.
// - sign zero lengthens that second by twice the magnitude minus one.
// - sign one shortens that second by twice inverted magnitude plus one.
// - magnitude bits five to one all zero leave the second unchanged.
// - trimming affects timekeeping only; crystal clock output stays untouched.
// - alarm one minute at address 8; bit 7 ignored on write, reads zero.
// - alarm one hour at address 9; bits 7 and 6 read zero, ignored.
// - alarm two minute, hour, weekday mask at B, C, D, same layouts.
// - hour bit 5 is pm indicator in 12-hour mode, twenty bit otherwise.
// - in 12-hour mode midnight encodes as 12 and noon as 32.
// - alarm one seven-bit weekday mask at address A; bit 7 reads zero.
// - mask bits 0 to 6 select weekday counter values 000 to 110.
// - an alarm with an all-zero weekday mask never signals.
// - match flag set on counter equality; software may only clear it.
// - enable zero disables the alarm and its flag reads zero.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ---------------------------------------------------------------
// internal addresses
// ---------------------------------------------------------------
`define RTC_ADDR_YEAR 4'h6
`define RTC_ADDR_TRIM 4'h7
`define RTC_ADDR_A1_MINUTE 4'h8
`define RTC_ADDR_A1_HOUR 4'h9
`define RTC_ADDR_A1_WEEKDAYS 4'ha
`define RTC_ADDR_A2_MINUTE 4'hb
`define RTC_ADDR_A2_HOUR 4'hc
`define RTC_ADDR_A2_WEEKDAYS 4'hd

// ---------------------------------------------------------------
// field layouts and reset values
// ---------------------------------------------------------------
`define RTC_MASK_MINUTE 8'h7f
`define RTC_MASK_HOUR 8'h3f
`define RTC_MASK_WEEKDAYS 8'h7f
`define RTC_TRIM_RESET 8'h00
`define RTC_REG_RESET 8'h00
`define RTC_TRIM_XSEL_BIT 7
`define RTC_TRIM_SIGN_BIT 6

// ---------------------------------------------------------------
// timing counts in oscillator pulses, trim-second marks as seconds values
// ---------------------------------------------------------------
`define RTC_COUNT_FAST 17'h08000
`define RTC_COUNT_SLOW 17'h07d00
`define RTC_SEC_MARK0 7'h00
`define RTC_SEC_MARK1 7'h20
`define RTC_SEC_MARK2 7'h40

`endif

// *** rtc_trim_alarm_regs.sv ***
// Purpose: year, time trim and two alarm register sets of a real-time clock
// Assumes: clock counters and enables come from the rest of the rtc on clock
// Notes: register port is the internal-address port behind the serial slave
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_trim_alarm_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic oscClk,
  input wire logic regWrite,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic oscillatorStoppedFlag,
  input wire logic [6:0] secondsCount,
  input wire logic [6:0] minuteCount,
  input wire logic [5:0] hourCount,
  input wire logic [2:0] weekdayCounter,
  input wire logic alarmOneEnable,
  input wire logic alarmTwoEnable,
  input wire logic alarmOneFlagClear,
  input wire logic alarmTwoFlagClear,
  output logic alarmOneMatchFlag,
  output logic alarmTwoMatchFlag,
  output logic secondTick,
  output logic crystalClockOut
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] yearCount_ff;
  logic [7:0] timeTrim_ff;
  rtc_pkg::rtc_alarm_s alarm_ff [2];
  logic [1:0] matchFlag_ff;
  logic [1:0] enable;
  logic [1:0] flagClear;
  logic [1:0] hit;
  logic trimSecond_ff;
  logic tickMeta_ff;
  logic tickSync_ff;
  logic tickLast_ff;
  logic tick_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  rtc_div_if divLink ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // weekday counter value to mask position; 111 selects nothing
  function automatic logic weekdayHit(input logic [6:0] mask, input logic [2:0] day);
    weekdayHit = 1'b0;
    if (day != 3'h7) begin
      weekdayHit = mask[day];
    end
  endfunction : weekdayHit

  // address to alarm index and field, used by the write path only
  function automatic logic [2:0] alarmSlot(input logic [3:0] addr);
    // {valid, set, field}: field 0 minute, 1 hour
    case (addr)
      `RTC_ADDR_A1_MINUTE: alarmSlot = 3'h4;
      `RTC_ADDR_A1_HOUR: alarmSlot = 3'h5;
      `RTC_ADDR_A2_MINUTE: alarmSlot = 3'h6;
      `RTC_ADDR_A2_HOUR: alarmSlot = 3'h7;
      default: alarmSlot = 3'h0;
    endcase
  endfunction : alarmSlot

  // ---------------------------------------------------------------
  // year register
  // ---------------------------------------------------------------
  // every bit writable; content after oscillator stop left as it was
  always_ff @(posedge clock) begin
    if (rst) begin
      yearCount_ff <= `RTC_REG_RESET;
    end else if (regWrite && (regAddr == `RTC_ADDR_YEAR)) begin
      yearCount_ff <= regWdata;
    end
  end

  // ---------------------------------------------------------------
  // trim register
  // ---------------------------------------------------------------
  // oscillator-stop default forces zero so a fresh start is untrimmed
  always_ff @(posedge clock) begin
    if (rst || oscillatorStoppedFlag) begin
      timeTrim_ff <= `RTC_TRIM_RESET;
    end else if (regWrite && (regAddr == `RTC_ADDR_TRIM)) begin
      timeTrim_ff <= regWdata;
    end
  end

  // ---------------------------------------------------------------
  // alarm register sets
  // ---------------------------------------------------------------
  // unused high bits are dropped on write
  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_ff[0] <= '0;
      alarm_ff[1] <= '0;
    end else if (regWrite) begin
      if (alarmSlot(regAddr) == 3'h4) begin
        alarm_ff[0].minute <= regWdata[6:0];
      end
      if (alarmSlot(regAddr) == 3'h5) begin
        alarm_ff[0].hour <= regWdata[5:0];
      end
      if (regAddr == `RTC_ADDR_A1_WEEKDAYS) begin
        alarm_ff[0].weekdays <= regWdata[6:0];
      end
      if (alarmSlot(regAddr) == 3'h6) begin
        alarm_ff[1].minute <= regWdata[6:0];
      end
      if (alarmSlot(regAddr) == 3'h7) begin
        alarm_ff[1].hour <= regWdata[5:0];
      end
      if (regAddr == `RTC_ADDR_A2_WEEKDAYS) begin
        alarm_ff[1].weekdays <= regWdata[6:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // alarm matching and flags
  // ---------------------------------------------------------------
  assign enable = {alarmTwoEnable, alarmOneEnable};
  assign flagClear = {alarmTwoFlagClear, alarmOneFlagClear};

  // hour compared as raw bits: same encoding as the hour counter in both modes,
  // so 12 for midnight and 32 for noon line up without translation
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gAlarm
      assign hit[gi] = (minuteCount == alarm_ff[gi].minute)
                    && (hourCount == alarm_ff[gi].hour)
                    && weekdayHit(alarm_ff[gi].weekdays, weekdayCounter);

      // set wins over a clear landing in the same cycle; disabled reads zero
      always_ff @(posedge clock) begin
        if (rst || !enable[gi]) begin
          matchFlag_ff[gi] <= 1'b0;
        end else if (hit[gi]) begin
          matchFlag_ff[gi] <= 1'b1;
        end else if (flagClear[gi]) begin
          matchFlag_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign alarmOneMatchFlag = matchFlag_ff[0];
  assign alarmTwoMatchFlag = matchFlag_ff[1];

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // addresses outside this block answer zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (regAddr)
      `RTC_ADDR_YEAR: nxt_rdata = yearCount_ff;
      `RTC_ADDR_TRIM: nxt_rdata = timeTrim_ff;
      `RTC_ADDR_A1_MINUTE: nxt_rdata = {1'b0, alarm_ff[0].minute};
      `RTC_ADDR_A1_HOUR: nxt_rdata = {2'b00, alarm_ff[0].hour};
      `RTC_ADDR_A1_WEEKDAYS: nxt_rdata = {1'b0, alarm_ff[0].weekdays};
      `RTC_ADDR_A2_MINUTE: nxt_rdata = {1'b0, alarm_ff[1].minute};
      `RTC_ADDR_A2_HOUR: nxt_rdata = {2'b00, alarm_ff[1].hour};
      `RTC_ADDR_A2_WEEKDAYS: nxt_rdata = {1'b0, alarm_ff[1].weekdays};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // registered answer, one cycle after the address
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign regRdata = rdata_ff;

  // ---------------------------------------------------------------
  // crossing to the oscillator divider
  // ---------------------------------------------------------------
  // registered so the crossing sees a glitch-free level
  always_ff @(posedge clock) begin
    if (rst) begin
      trimSecond_ff <= 1'b0;
    end else begin
      trimSecond_ff <= (secondsCount == `RTC_SEC_MARK0)
                    || (secondsCount == `RTC_SEC_MARK1)
                    || (secondsCount == `RTC_SEC_MARK2);
    end
  end

  assign divLink.trimCode = timeTrim_ff;
  assign divLink.trimSecond = trimSecond_ff;
  assign divLink.resetLevel = rst;

  rtc_trim_divider uDivider (
    .oscClk(oscClk),
    .link(divLink)
  );

  // toggle back from the divider: sync, then edge on synced copies only
  always_ff @(posedge clock) begin
    if (rst) begin
      tickMeta_ff <= 1'b0;
      tickSync_ff <= 1'b0;
      tickLast_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      tickMeta_ff <= divLink.tickToggle;
      tickSync_ff <= tickMeta_ff;
      tickLast_ff <= tickSync_ff;
      tick_ff <= tickSync_ff ^ tickLast_ff;
    end
  end

  assign secondTick = tick_ff;

  // raw crystal rate, deliberately bypassing the trimmed divider
  assign crystalClockOut = oscClk;

endmodule : rtc_trim_alarm_regs
`default_nettype wire

// *** rtc_trim_alarm_regs_sva.sv ***
// Purpose: port checks of the rtc trim/alarm block
// Assumes: sees only top ports, single register clock
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module rtc_trim_alarm_regs_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic oscClk,
  input wire logic regWrite,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic oscillatorStoppedFlag,
  input wire logic [2:0] weekdayCounter,
  input wire logic alarmOneEnable,
  input wire logic alarmTwoEnable,
  input wire logic alarmOneFlagClear,
  input wire logic alarmOneMatchFlag,
  input wire logic alarmTwoMatchFlag,
  input wire logic secondTick,
  input wire logic crystalClockOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----
  // register port
  // ----
  sequence s_year_write;
    regWrite && regAddr == 4'h6 ##1 !regWrite && regAddr == 4'h6;
  endsequence
  sequence s_stop_then_trim;
    oscillatorStoppedFlag && !regWrite ##1 !regWrite && regAddr == 4'h7;
  endsequence
  a_year_write_back: assert property (s_year_write |=> regRdata == $past(regWdata, 2))
    else $error("year readback differs from write");
  a_stop_clears_trim: assert property (s_stop_then_trim |=> regRdata == 8'h00)
    else $error("trim not cleared by oscillator stop");
  a_unmapped_reads_zero: assert property ((regAddr < 4'h6 || regAddr > 4'hd) |=> regRdata == 8'h00)
    else $error("unmapped address reads nonzero");
  a_minute_top_zero: assert property (regAddr inside {4'h8, 4'ha, 4'hb, 4'hd} |=> !regRdata[7])
    else $error("minute or weekday bit 7 reads one");
  a_hour_top_zero: assert property ((regAddr == 4'h9 || regAddr == 4'hc) |=> regRdata[7:6] == 2'b00)
    else $error("hour bits 7 and 6 read nonzero");
  // ----
  // alarms, tick and clock output
  // ----
  a_one_disabled_zero: assert property (!alarmOneEnable |=> !alarmOneMatchFlag)
    else $error("alarm one flag high while disabled");
  a_two_disabled_zero: assert property (!alarmTwoEnable |=> !alarmTwoMatchFlag)
    else $error("alarm two flag high while disabled");
  a_flag_stays_set: assert property (alarmOneMatchFlag && alarmOneEnable && !alarmOneFlagClear |=> alarmOneMatchFlag)
    else $error("alarm one flag dropped without clear");
  a_no_day_seven: assert property (weekdayCounter == 3'h7 |=> !$rose(alarmOneMatchFlag))
    else $error("alarm one set on weekday seven");
  a_tick_one_cycle: assert property (secondTick |=> !secondTick)
    else $error("second tick longer than one cycle");
  a_clock_out_copy: assert property (crystalClockOut == oscClk)
    else $error("crystal clock output differs from oscillator");
endmodule : rtc_trim_alarm_regs_sva

bind rtc_trim_alarm_regs rtc_trim_alarm_regs_sva rtc_trim_alarm_regs_sva_i (
  .clock(clock), .rst(rst), .oscClk(oscClk), .regWrite(regWrite), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .oscillatorStoppedFlag(oscillatorStoppedFlag),
  .weekdayCounter(weekdayCounter), .alarmOneEnable(alarmOneEnable),
  .alarmTwoEnable(alarmTwoEnable), .alarmOneFlagClear(alarmOneFlagClear),
  .alarmOneMatchFlag(alarmOneMatchFlag), .alarmTwoMatchFlag(alarmTwoMatchFlag),
  .secondTick(secondTick), .crystalClockOut(crystalClockOut));
`default_nettype wire

// *** rtc_trim_alarm_regs_tb.sv ***
// Purpose: self-checking bench of the rtc trim/alarm block
// Assumes: host model on the register port, counters driven here
// Notes: a trimmed second is ~800k cycles, so divider timing is left unchecked; assertions only bound the tick width
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module rtc_trim_alarm_regs_tb;
  typedef struct packed {logic [3:0] addr; logic [7:0] wdata; logic [7:0] rdata;} rtc_row_s;
  localparam rtc_row_s rows [10] = '{'{4'h6, 8'hff, 8'hff}, '{4'h7, 8'ha5, 8'ha5},
    '{4'h8, 8'hff, 8'h7f}, '{4'h9, 8'hff, 8'h3f}, '{4'ha, 8'hff, 8'h7f}, '{4'hb, 8'h80, 8'h00},
    '{4'hc, 8'hc5, 8'h05}, '{4'hd, 8'hff, 8'h7f}, '{4'h3, 8'hff, 8'h00}, '{4'he, 8'hff, 8'h00}};
  logic clock, rst, oscClk, stopFlag;
  logic [6:0] minuteCount;
  logic [5:0] hourCount;
  logic [2:0] weekdayCounter;
  logic [1:0] en, clr;
  wire logic [1:0] flag;
  wire logic regWrite;
  wire logic [3:0] regAddr;
  wire logic [7:0] regWdata;
  logic [7:0] regRdata;
  wire logic tick;
  wire logic xtal;
  logic [6:0] secs;
  int mismatches = 0;
  int nTests = 0;
  logic [3:0] b;

  rtc_host_model rtc_host_model_i (.clock(clock), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata));
  rtc_trim_alarm_regs rtc_trim_alarm_regs_i (.clock(clock), .rst(rst), .oscClk(oscClk),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .oscillatorStoppedFlag(stopFlag), .secondsCount(secs), .minuteCount(minuteCount),
    .hourCount(hourCount), .weekdayCounter(weekdayCounter), .alarmOneEnable(en[0]),
    .alarmTwoEnable(en[1]), .alarmOneFlagClear(clr[0]), .alarmTwoFlagClear(clr[1]),
    .alarmOneMatchFlag(flag[0]), .alarmTwoMatchFlag(flag[1]), .secondTick(tick),
    .crystalClockOut(xtal));

  // ----
  // clocks and watchdog
  // ----
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    oscClk = 1'b0;
    #37; // odd offset keeps the two clocks unrelated in phase
    forever #62.5 oscClk = ~oscClk;
  end
  initial begin
    #300us;
    mismatches++;
    conclude();
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // counters change off the falling edge, then two edges let the flag land
  task automatic setDay(input logic [2:0] d);
    @(negedge clock);
    weekdayCounter = d;
    repeat (2) @(negedge clock);
  endtask : setDay

  // ----
  // main sequence
  // ----
  initial begin
    rst = 1'b1;
    stopFlag = 1'b0;
    secs = 7'h00;
    minuteCount = 7'h00;
    hourCount = 6'h00;
    weekdayCounter = 3'h0;
    en = 2'b00;
    clr = 2'b00;
    // longer than ten cycles: the divider reset needs three oscillator periods
    repeat (80) @(negedge clock);
    rst = 1'b0;
    for (int a = 6; a < 14; a++) begin
      rtc_host_model_i.pointTo(4'(a));
      `CHK("reset value", 8'h00, regRdata)
    end
    `CHK("tick idle", 1'b0, tick)
    `CHK("crystal out", oscClk, xtal)
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      rtc_host_model_i.wr(rows[i].addr, rows[i].wdata);
      rtc_host_model_i.pointTo(rows[i].addr);
      `CHK("row read", rows[i].rdata, regRdata)
    end
    $display("test rows done");
    rtc_host_model_i.wr(4'h7, 8'hc3);
    rtc_host_model_i.wr(4'h6, 8'h99);
    rtc_host_model_i.pointTo(4'h7);
    `CHK("trim before stop", 8'hc3, regRdata)
    @(negedge clock);
    stopFlag = 1'b1;
    @(negedge clock);
    stopFlag = 1'b0;
    rtc_host_model_i.pointTo(4'h7);
    `CHK("trim after stop", 8'h00, regRdata)
    rtc_host_model_i.pointTo(4'h6);
    `CHK("year after stop", 8'h99, regRdata)
    $display("test stop done");
    for (int k = 0; k < 2; k++) begin
      b = (k == 1) ? 4'hb : 4'h8;
      rtc_host_model_i.wr(b, 8'h30);
      rtc_host_model_i.wr(b + 4'h1, 8'h32);
      rtc_host_model_i.wr(b + 4'h2, 8'h02);
      minuteCount = 7'h30;
      hourCount = 6'h32;
      en[k] = 1'b1;
      setDay(3'h1);
      `CHK("flag on hit", 1'b1, flag[k])
      `CHK("other flag", 1'b0, flag[1-k])
      clr[k] = 1'b1;
      @(negedge clock);
      clr[k] = 1'b0;
      setDay(3'h2);
      `CHK("set beats clear", 1'b1, flag[k])
      clr[k] = 1'b1;
      @(negedge clock);
      clr[k] = 1'b0;
      setDay(3'h2);
      `CHK("flag cleared", 1'b0, flag[k])
      en[k] = 1'b0;
      setDay(3'h1);
      `CHK("flag disabled", 1'b0, flag[k])
      rtc_host_model_i.wr(b + 4'h2, 8'h7f);
      setDay(3'h7);
      en[k] = 1'b1;
      setDay(3'h7);
      `CHK("weekday seven", 1'b0, flag[k])
      setDay(3'h6);
      `CHK("mask bit six", 1'b1, flag[k])
      setDay(3'h7);
      clr[k] = 1'b1;
      @(negedge clock);
      clr[k] = 1'b0;
      rtc_host_model_i.wr(b + 4'h2, 8'h00);
      setDay(3'h1);
      `CHK("empty mask", 1'b0, flag[k])
      en[k] = 1'b0;
      $display("test alarm %0d done", k);
    end
    conclude();
  end
endmodule : rtc_trim_alarm_regs_tb
`default_nettype wire

// *** rtc_trim_divider.sv ***
// Purpose: trimmed one-second divider on the oscillator clock
// Assumes: trim code and trim-second level change slowly versus oscClk
// Notes: emits one toggle per second toward the register domain
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_trim_divider (
  input wire logic oscClk,
  rtc_div_if.div link
);

  logic [7:0] codeMeta_ff;
  logic [7:0] codeSync_ff;
  logic [7:0] codeUse_ff;
  logic trimMeta_ff;
  logic trimSync_ff;
  logic rstMeta_ff;
  logic rstSync_ff;
  logic [16:0] count_ff;
  logic tick_ff;
  logic [16:0] period;

  // ---------------------------------------------------------------
  // length of the current second
  // ---------------------------------------------------------------
  function automatic logic [16:0] secondLength(input logic [7:0] code, input logic trimNow);
    logic [16:0] base;
    logic [5:0] mag;
    logic [6:0] shortBy;
    logic [6:0] longBy;
    base = code[`RTC_TRIM_XSEL_BIT] ? `RTC_COUNT_SLOW : `RTC_COUNT_FAST;
    mag = code[5:0];
    shortBy = {1'b0, ~mag} + 7'h01;
    longBy = {1'b0, mag} - 7'h01;
    secondLength = base;
    if (trimNow && (mag[5:1] != 5'h00)) begin
      if (!code[`RTC_TRIM_SIGN_BIT]) begin
        secondLength = base + {9'h000, longBy, 1'b0};
      end else begin
        secondLength = base - {9'h000, shortBy, 1'b0};
      end
    end
  endfunction : secondLength

  // two-flop synchronisers for everything arriving from the register domain
  always_ff @(posedge oscClk) begin
    codeMeta_ff <= link.trimCode;
    codeSync_ff <= codeMeta_ff;
    // a multi-bit word may land skewed; take it only once two stages agree
    if (codeMeta_ff == codeSync_ff) begin
      codeUse_ff <= codeSync_ff;
    end
    trimMeta_ff <= link.trimSecond;
    trimSync_ff <= trimMeta_ff;
    rstMeta_ff <= link.resetLevel;
    rstSync_ff <= rstMeta_ff;
  end

  // compared every pulse: the trim-second level settles a few pulses into the second
  assign period = secondLength(codeUse_ff, trimSync_ff);

  // up-counter; the crystal output is never derived from here
  always_ff @(posedge oscClk) begin
    if (rstSync_ff) begin
      count_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else if (count_ff >= (period - 17'h00001)) begin
      count_ff <= 17'h00000;
      tick_ff <= ~tick_ff;
    end else begin
      count_ff <= count_ff + 17'h00001;
    end
  end

  assign link.tickToggle = tick_ff;

endmodule : rtc_trim_divider
`default_nettype wire
